//--- rst_pkg.sv
package rst_pkg;

    // bus decode
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_NMI_FLAGS = 12'h000;
    localparam logic [11:0] OFS_NMI_CLEAR = 12'h004;
    localparam logic [11:0] OFS_NMI_FORCE = 12'h008;
    localparam logic [11:0] OFS_NMI_WD_CTRL = 12'h00C;
    localparam logic [11:0] OFS_NMI_WD_PERIOD = 12'h010;
    localparam logic [11:0] OFS_CTL_RESET_CONFIG = 12'h014;
    localparam logic [11:0] OFS_CTL_RESET_STATUS = 12'h018;
    localparam logic [11:0] OFS_PERIPH_SOFT_RESET = 12'h01C;
    localparam logic [11:0] OFS_DEVICE_CONFIG = 12'h020;
    localparam logic [11:0] OFS_HOST_RESET_CAUSE = 12'h024;
    localparam logic [11:0] OFS_DEVICE_CONFIG_STATUS = 12'h028;

    // field positions
    localparam int NMI_SRC_W = 7;
    localparam int WD_CTRL_DISABLE_BIT = 0;
    localparam int CFG_CTL_SEL_BIT = 0;
    localparam int CFG_ANALOG_BUS_BIT = 1;
    localparam int CFG_PROPAGATE_BIT = 2;
    localparam int CAUSE_EXT_BIT = 0;
    localparam int CAUSE_POR_BIT = 1;
    localparam int CAUSE_WD0_BIT = 2;
    localparam int CAUSE_WD1_BIT = 3;
    localparam int CAUSE_SW_BIT = 4;
    localparam int STS_ANALOG_BUS_BIT = 0;
    localparam int STS_MAIN_PIN_BIT = 1;
    localparam int PERIPH_N = 8;
    localparam int WD_W = 16;

    // reset values
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [15:0] WD_PERIOD_RST = 16'h0400;
    localparam logic [4:0] CAUSE_RST = 5'h02;
    localparam logic [7:0] DEVCFG_RST = 8'hFF;

    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PIN_PULSE_NS = 1000;
    localparam int PIN_PULSE_CYCLES = (PIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WD_RST_NS = 100;
    localparam int WD_RST_CYCLES = (WD_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_W = 9;

    // critical condition inputs of the control-side nmi logic
    typedef struct packed {
        logic host_selftest_err;
        logic ctl_selftest_err;
        logic vector_fetch_err;
        logic flash_uncorrectable;
        logic ram_uncorrectable;
        logic analog_bus_err;
        logic osc_missing;
    } nmi_src_t;

    // selective reset configuration
    typedef struct packed {
        logic propagate_en;
        logic analog_bus_reset;
        logic ctl_sel_reset_bit;
    } ctl_reset_config_t;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_COUNT = 2'b01,
        WD_FIRE = 2'b10
    } wd_state_t;

endpackage

//--- dual_core_reset_nmi_router.sv
`timescale 1ns/1ps

module reset_sync (
    input wire logic pclk,
    input wire logic arst_n,
    output logic rst_n
);
    logic meta_q;
    logic sync_q;

    // async assert, two-stage synchronous release
    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign rst_n = sync_q;
endmodule

module dual_core_reset_nmi_router (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [rst_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rst_pkg::nmi_src_t nmi_src,
    input wire logic main_reset_pin_n_in,
    output logic main_reset_pin_n_out,
    output logic main_reset_pin_n_oe,
    input wire logic analog_reset_pin_n_in,
    output logic analog_reset_pin_n_out,
    output logic analog_reset_pin_n_oe,
    input wire logic host_vmon_trip,
    input wire logic analog_vmon_trip,
    input wire logic host_wd0_timeout,
    input wire logic host_wd1_timeout,
    input wire logic host_nmi_wd_timeout,
    input wire logic soft_reset_req,
    input wire logic debug_reset_req,
    output logic ctl_nmi_irq,
    output logic ctl_nmi_wd_event,
    output logic ctl_nmi_wd_reset,
    output logic host_sys_reset_n,
    output logic ext_periph_iface_reset_n,
    output logic ctl_cpu_reset_in_n,
    output logic ctl_sys_reset_n,
    output logic shared_reset_n,
    output logic analog_reset_n,
    output logic analog_bus_reset_n,
    output logic [rst_pkg::PERIPH_N-1:0] periph_reset_n
);
    import rst_pkg::*;

    logic [NMI_SRC_W-1:0] flags_q, flags_d;
    logic irq_q, irq_d;
    wd_state_t wd_state_q, wd_state_d;
    logic [WD_W-1:0] wd_cnt_q, wd_cnt_d;
    logic [WD_W-1:0] wd_period_q, wd_period_d;
    logic wd_event_q, wd_event_d;
    logic wd_rst_q, wd_rst_d;
    ctl_reset_config_t cfg_q, cfg_d;
    logic [PERIPH_N-1:0] soft_q, soft_d;
    logic [PERIPH_N-1:0] devcfg_q, devcfg_d;
    logic [4:0] cause_q, cause_d;
    logic [PULSE_W-1:0] main_cnt_q, main_cnt_d;
    logic [PULSE_W-1:0] ana_cnt_q, ana_cnt_d;
    logic main_oe_q, main_oe_d;
    logic ana_oe_q, ana_oe_d;
    logic host_req_q, host_req_d;
    logic ctl_req_q, ctl_req_d;
    logic shr_req_q, shr_req_d;
    logic ana_req_q, ana_req_d;
    logic bus_req_q, bus_req_d;
    logic [PERIPH_N-1:0] periph_q, periph_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic setup, wr_acc, wr_clr, wr_frc, wr_wdc;
    logic host_rst_sync, ctl_cpu_sync, ctl_sys_sync, shr_sync, ana_sync, bus_sync;
    logic soft_or_dbg;
    logic main_trig;

    // apb strobes; writes land in the access phase
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && ready_q && pwrite;
    assign wr_clr = wr_acc && (paddr == OFS_NMI_CLEAR);
    assign wr_frc = wr_acc && (paddr == OFS_NMI_FORCE);
    assign wr_wdc = wr_acc && (paddr == OFS_NMI_WD_CTRL);
    assign soft_or_dbg = soft_reset_req || debug_reset_req;
    assign main_trig = host_vmon_trip || host_wd0_timeout || host_wd1_timeout || host_nmi_wd_timeout;

    // nmi flags: set beats clear, force sets
    always_comb begin
        flags_d = flags_q;
        if (wr_clr) begin
            flags_d = flags_d & ~pwdata[NMI_SRC_W-1:0];
        end
        if (wr_frc) begin
            flags_d = flags_d | pwdata[NMI_SRC_W-1:0];
        end
        flags_d = flags_d | nmi_src;
        irq_d = |flags_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q <= irq_d;
        end
    end

    // control-side nmi watchdog
    always_comb begin
        wd_state_d = wd_state_q;
        wd_cnt_d = wd_cnt_q;
        wd_event_d = 1'b0;
        wd_rst_d = 1'b0;
        case (wd_state_q)
            WD_IDLE: begin
                if (irq_d && !irq_q) begin
                    wd_state_d = WD_COUNT;
                    wd_cnt_d = wd_period_q;
                    wd_event_d = 1'b1;
                end
            end
            WD_COUNT: begin
                if (wr_wdc && pwdata[WD_CTRL_DISABLE_BIT]) begin
                    wd_state_d = WD_IDLE;
                end else if (wd_cnt_q <= 16'h0001) begin
                    wd_state_d = WD_FIRE;
                    wd_cnt_d = WD_W'(WD_RST_CYCLES);
                    wd_rst_d = 1'b1;
                end else begin
                    wd_cnt_d = wd_cnt_q - 16'h0001;
                end
            end
            WD_FIRE: begin
                if (wd_cnt_q <= 16'h0001) begin
                    wd_state_d = WD_IDLE;
                end else begin
                    wd_cnt_d = wd_cnt_q - 16'h0001;
                    wd_rst_d = 1'b1;
                end
            end
            default: begin
                wd_state_d = WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_state_q <= WD_IDLE;
            wd_cnt_q <= '0;
            wd_event_q <= 1'b0;
            wd_rst_q <= 1'b0;
        end else begin
            wd_state_q <= wd_state_d;
            wd_cnt_q <= wd_cnt_d;
            wd_event_q <= wd_event_d;
            wd_rst_q <= wd_rst_d;
        end
    end

    // software registers and reset cause
    always_comb begin
        wd_period_d = wd_period_q;
        cfg_d = cfg_q;
        soft_d = soft_q;
        devcfg_d = devcfg_q;
        cause_d = cause_q;
        if (wr_acc) begin
            case (paddr)
                OFS_NMI_WD_PERIOD: wd_period_d = pwdata[WD_W-1:0];
                OFS_CTL_RESET_CONFIG: cfg_d = pwdata[2:0];
                OFS_PERIPH_SOFT_RESET: soft_d = pwdata[PERIPH_N-1:0];
                OFS_DEVICE_CONFIG: devcfg_d = pwdata[PERIPH_N-1:0];
                OFS_HOST_RESET_CAUSE: cause_d = cause_q & ~pwdata[4:0];
                default: cause_d = cause_q;
            endcase
        end
        // new causes win over a clearing write
        if (!main_reset_pin_n_in) cause_d[CAUSE_EXT_BIT] = 1'b1;
        if (host_vmon_trip) cause_d[CAUSE_POR_BIT] = 1'b1;
        if (host_wd0_timeout) cause_d[CAUSE_WD0_BIT] = 1'b1;
        if (host_wd1_timeout) cause_d[CAUSE_WD1_BIT] = 1'b1;
        if (soft_reset_req) cause_d[CAUSE_SW_BIT] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_period_q <= WD_PERIOD_RST;
            cfg_q <= CFG_RST;
            soft_q <= '0;
            devcfg_q <= DEVCFG_RST;
            cause_q <= CAUSE_RST;
        end else begin
            wd_period_q <= wd_period_d;
            cfg_q <= cfg_d;
            soft_q <= soft_d;
            devcfg_q <= devcfg_d;
            cause_q <= cause_d;
        end
    end

    // open-drain pin pulse stretchers
    always_comb begin
        main_cnt_d = main_cnt_q;
        ana_cnt_d = ana_cnt_q;
        if (main_trig) begin
            main_cnt_d = PULSE_W'(PIN_PULSE_CYCLES);
        end else if (main_cnt_q != '0) begin
            main_cnt_d = main_cnt_q - 1'b1;
        end
        if (analog_vmon_trip) begin
            ana_cnt_d = PULSE_W'(PIN_PULSE_CYCLES);
        end else if (ana_cnt_q != '0) begin
            ana_cnt_d = ana_cnt_q - 1'b1;
        end
        main_oe_d = main_cnt_d != '0;
        ana_oe_d = ana_cnt_d != '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_cnt_q <= '0;
            ana_cnt_q <= '0;
            main_oe_q <= 1'b0;
            ana_oe_q <= 1'b0;
        end else begin
            main_cnt_q <= main_cnt_d;
            ana_cnt_q <= ana_cnt_d;
            main_oe_q <= main_oe_d;
            ana_oe_q <= ana_oe_d;
        end
    end

    // registered reset requests keep glitches off the async clears
    always_comb begin
        host_req_d = !main_reset_pin_n_in || host_wd0_timeout || host_wd1_timeout
            || host_nmi_wd_timeout || soft_or_dbg;
        ctl_req_d = !main_reset_pin_n_in || wd_rst_q || (soft_or_dbg && cfg_q.propagate_en)
            || cfg_q.ctl_sel_reset_bit;
        shr_req_d = !main_reset_pin_n_in || (soft_or_dbg && cfg_q.propagate_en);
        ana_req_d = shr_req_d || cfg_q.analog_bus_reset || !analog_reset_pin_n_in;
        bus_req_d = cfg_q.analog_bus_reset;
        periph_d = {PERIPH_N{host_rst_sync}} & ~(soft_q & devcfg_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_req_q <= 1'b0;
            ctl_req_q <= 1'b0;
            shr_req_q <= 1'b0;
            ana_req_q <= 1'b0;
            bus_req_q <= 1'b0;
            periph_q <= '0;
        end else begin
            host_req_q <= host_req_d;
            ctl_req_q <= ctl_req_d;
            shr_req_q <= shr_req_d;
            ana_req_q <= ana_req_d;
            bus_req_q <= bus_req_d;
            periph_q <= periph_d;
        end
    end

    // reset domains: async assert, sync release
    reset_sync u_host (.pclk(pclk), .arst_n(presetn && !host_req_q), .rst_n(host_rst_sync));
    reset_sync u_ctl_cpu (.pclk(pclk), .arst_n(presetn && !ctl_req_q), .rst_n(ctl_cpu_sync));
    reset_sync u_ctl_sys (.pclk(pclk), .arst_n(ctl_cpu_sync), .rst_n(ctl_sys_sync));
    reset_sync u_shared (.pclk(pclk), .arst_n(presetn && !shr_req_q), .rst_n(shr_sync));
    reset_sync u_analog (.pclk(pclk), .arst_n(presetn && !ana_req_q), .rst_n(ana_sync));
    reset_sync u_bus (.pclk(pclk), .arst_n(presetn && !bus_req_q), .rst_n(bus_sync));

    // apb read data and handshake, no wait states
    always_comb begin
        rdata_d = '0;
        err_d = 1'b0;
        ready_d = setup;
        if (setup) begin
            case (paddr)
                OFS_NMI_FLAGS: rdata_d = 32'(flags_q);
                OFS_NMI_CLEAR: rdata_d = '0;
                OFS_NMI_FORCE: rdata_d = '0;
                OFS_NMI_WD_CTRL: rdata_d = 32'(wd_state_q);
                OFS_NMI_WD_PERIOD: rdata_d = 32'(wd_period_q);
                OFS_CTL_RESET_CONFIG: rdata_d = 32'(cfg_q);
                OFS_CTL_RESET_STATUS: rdata_d = 32'(!ctl_sys_sync);
                OFS_PERIPH_SOFT_RESET: rdata_d = 32'(soft_q);
                OFS_DEVICE_CONFIG: rdata_d = 32'(devcfg_q);
                OFS_HOST_RESET_CAUSE: rdata_d = 32'(cause_q);
                OFS_DEVICE_CONFIG_STATUS: rdata_d = 32'({main_reset_pin_n_in, bus_sync});
                default: err_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign ctl_nmi_irq = irq_q;
    assign ctl_nmi_wd_event = wd_event_q;
    assign ctl_nmi_wd_reset = wd_rst_q;
    assign main_reset_pin_n_out = !main_oe_q;
    assign main_reset_pin_n_oe = main_oe_q;
    assign analog_reset_pin_n_out = !ana_oe_q;
    assign analog_reset_pin_n_oe = ana_oe_q;
    assign host_sys_reset_n = host_rst_sync;
    assign ext_periph_iface_reset_n = host_rst_sync;
    assign ctl_cpu_reset_in_n = ctl_cpu_sync;
    assign ctl_sys_reset_n = ctl_sys_sync;
    assign shared_reset_n = shr_sync;
    assign analog_reset_n = ana_sync;
    assign analog_bus_reset_n = bus_sync;
    assign periph_reset_n = periph_q;

    // checks
    property p_irq;
        @(posedge pclk) disable iff (!presetn) (nmi_src != '0) |=> ctl_nmi_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("nmi not raised");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
            (wr_clr && pwdata[0] && !wr_frc && !nmi_src[0]) |=> !flags_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_force;
        @(posedge pclk) disable iff (!presetn) (wr_frc && pwdata[3]) |=> flags_q[3] ##1 ctl_nmi_irq;
    endproperty
    a_force: assert property (p_force) else $error("force failed");

    property p_wd_fire;
        @(posedge pclk) disable iff (!presetn)
            (wd_state_q == WD_COUNT && wd_cnt_q == 16'h0001 && !wr_wdc) |=> ctl_nmi_wd_reset ##2 !ctl_cpu_reset_in_n;
    endproperty
    a_wd_fire: assert property (p_wd_fire) else $error("watchdog reset missing");

    property p_main_pulse;
        @(posedge pclk) disable iff (!presetn) main_trig |=> (main_reset_pin_n_oe && !main_reset_pin_n_out) [*8];
    endproperty
    a_main_pulse: assert property (p_main_pulse) else $error("main pin pulse short");

    property p_host_soft;
        @(posedge pclk) disable iff (!presetn) soft_reset_req |-> ##[1:3] !host_sys_reset_n;
    endproperty
    a_host_soft: assert property (p_host_soft) else $error("host reset missing");

    property p_pin_ctl;
        @(posedge pclk) disable iff (!presetn) !main_reset_pin_n_in |-> ##[1:3] (!ctl_cpu_reset_in_n && !shared_reset_n);
    endproperty
    a_pin_ctl: assert property (p_pin_ctl) else $error("pin reset not routed");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
            ($past(soft_or_dbg) && !$past(cfg_q.propagate_en) && main_reset_pin_n_in && $past(main_reset_pin_n_in)
             && !$past(cfg_q.ctl_sel_reset_bit) && !$past(wd_rst_q)) |-> !ctl_req_q;
    endproperty
    a_gate: assert property (p_gate) else $error("ungated soft reset");

    property p_cause;
        @(posedge pclk) disable iff (!presetn) host_wd0_timeout |=> cause_q[CAUSE_WD0_BIT];
    endproperty
    a_cause: assert property (p_cause) else $error("cause not recorded");

    c_wd_fire: cover property (@(posedge pclk) disable iff (!presetn) $rose(ctl_nmi_wd_reset));
    c_force: cover property (@(posedge pclk) disable iff (!presetn) wr_frc ##1 ctl_nmi_irq);
    c_pulse: cover property (@(posedge pclk) disable iff (!presetn) $rose(main_reset_pin_n_oe));
    c_sel: cover property (@(posedge pclk) disable iff (!presetn) cfg_q.ctl_sel_reset_bit ##3 !ctl_sys_reset_n);
endmodule

//--- board_model.sv
`timescale 1ns/1ps
module board_model (
    input wire logic pclk,
    input wire logic main_hold,
    input wire logic analog_hold,
    input wire logic main_oe,
    input wire logic main_out,
    input wire logic analog_oe,
    input wire logic analog_out,
    output logic main_pin,
    output logic analog_pin
);
    logic [3:0] pwr_cnt = 4'h0;
    // power-up hold counter of the board supervisor
    always @(posedge pclk) begin
        if (pwr_cnt < 4'h8) begin
            pwr_cnt <= pwr_cnt + 4'h1;
        end
    end
    // wired-and pins with pull-ups, low while either side pulls
    assign main_pin = (main_oe ? main_out : 1'b1) & !(main_hold || pwr_cnt < 4'h8);
    assign analog_pin = (analog_oe ? analog_out : 1'b1) & !analog_hold;
endmodule

//--- dual_core_reset_nmi_router_tb_top.sv
`timescale 1ns/1ps
module dual_core_reset_nmi_router_tb_top;
    import rst_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, main_hold = 1'b0, analog_hold = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [6:0] req = '0;
    nmi_src_t nmi_src = '0;
    logic pready, pslverr, main_pin, analog_pin, main_reset_pin_n_out, main_reset_pin_n_oe;
    logic analog_reset_pin_n_out, analog_reset_pin_n_oe, ctl_nmi_irq, ctl_nmi_wd_event, ctl_nmi_wd_reset;
    logic host_sys_reset_n, ext_periph_iface_reset_n, ctl_cpu_reset_in_n, ctl_sys_reset_n;
    logic shared_reset_n, analog_reset_n, analog_bus_reset_n;
    logic [PERIPH_N-1:0] periph_reset_n;
    int n_fail = 0;
    int comparisons = 0;

    // 250 MHz clock
    always #2 pclk = ~pclk;

    dual_core_reset_nmi_router dual_core_reset_nmi_router_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .nmi_src,
        .main_reset_pin_n_in(main_pin), .main_reset_pin_n_out, .main_reset_pin_n_oe,
        .analog_reset_pin_n_in(analog_pin), .analog_reset_pin_n_out, .analog_reset_pin_n_oe,
        .host_vmon_trip(req[0]), .analog_vmon_trip(req[1]), .host_wd0_timeout(req[2]),
        .host_wd1_timeout(req[3]), .host_nmi_wd_timeout(req[4]), .soft_reset_req(req[5]),
        .debug_reset_req(req[6]), .ctl_nmi_irq, .ctl_nmi_wd_event, .ctl_nmi_wd_reset, .host_sys_reset_n,
        .ext_periph_iface_reset_n, .ctl_cpu_reset_in_n, .ctl_sys_reset_n, .shared_reset_n, .analog_reset_n,
        .analog_bus_reset_n, .periph_reset_n
    );

    board_model board_model_inst (
        .pclk, .main_hold, .analog_hold, .main_oe(main_reset_pin_n_oe), .main_out(main_reset_pin_n_out),
        .analog_oe(analog_reset_pin_n_oe), .analog_out(analog_reset_pin_n_out), .main_pin, .analog_pin
    );

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk({31'h0, pready}, 32'h1, "apb no answer");
        if (pready !== 1'b1) test_done();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m, input string s);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp, s);
    endtask

    function automatic logic sig(input int i);
        case (i)
            0: return host_sys_reset_n;
            1: return ctl_cpu_reset_in_n;
            2: return ctl_sys_reset_n;
            3: return shared_reset_n;
            4: return analog_reset_n;
            5: return analog_bus_reset_n;
            6: return main_reset_pin_n_oe;
            7: return analog_reset_pin_n_oe;
            8: return ctl_nmi_wd_reset;
            9: return ext_periph_iface_reset_n;
            11: return ctl_nmi_wd_event;
            default: return ctl_nmi_irq;
        endcase
    endfunction

    // cause bit expected for each host reset source
    function automatic logic [31:0] cause_of(input int i);
        return (i == 0) ? 32'h2 : (i == 2) ? 32'h4 : (i == 3) ? 32'h8 : 32'h0;
    endfunction

    task automatic wait_for(input int i, input logic v, input int lim, input string s);
        int k;
        k = 0;
        while (sig(i) !== v && k < lim) begin
            @(posedge pclk);
            k++;
        end
        chk({31'h0, sig(i)}, {31'h0, v}, s);
        if (sig(i) !== v) test_done();
    endtask

    task automatic hold(input int i, input logic v, input int n, input string s);
        repeat (n) begin
            @(posedge pclk);
            chk({31'h0, sig(i)}, {31'h0, v}, s);
        end
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        req[i] <= 1'b1;
        @(posedge pclk);
        req[i] <= 1'b0;
    endtask

    initial begin
        logic [31:0] r, m;
        logic e;
        int p, b;
        void'($urandom(32'hd28f));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_for(0, 1'b1, 40, "host release");
        wait_for(2, 1'b1, 40, "ctl release");
        rd(OFS_HOST_RESET_CAUSE, 32'h2, 32'h2, "por cause");
        rd(OFS_DEVICE_CONFIG, 32'hFF, 32'hFF, "devcfg");
        apb(1'b0, 12'hFFC, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "unmapped");
        $display("test reset done");
        for (int i = 0; i < NMI_SRC_W; i++) begin
            @(posedge pclk);
            nmi_src <= nmi_src_t'(7'h1 << i);
            @(posedge pclk);
            nmi_src <= '0;
            wait_for(10, 1'b1, 4, "irq");
            rd(OFS_NMI_FLAGS, 32'h1 << i, 32'h7F, "flag");
            wr(OFS_NMI_CLEAR, 32'h1 << i);
            rd(OFS_NMI_FLAGS, 32'h0, 32'h7F, "clear");
            wait_for(10, 1'b0, 4, "irq off");
        end
        wr(OFS_NMI_WD_CTRL, 32'h1);
        rd(OFS_NMI_WD_CTRL, 32'h0, 32'h3, "wd idle");
        hold(8, 1'b0, 1100, "wd disabled");
        p = 8 + ($urandom % 16);
        b = $urandom % NMI_SRC_W;
        wr(OFS_NMI_WD_PERIOD, p);
        wr(OFS_NMI_FORCE, 32'h1 << b);
        wait_for(11, 1'b1, 2, "wd start event");
        wait_for(8, 1'b1, p + 10, "wd fire");
        wait_for(1, 1'b0, 4, "wd ctl reset");
        rd(OFS_NMI_FLAGS, 32'h1 << b, 32'h7F, "forced");
        wr(OFS_NMI_CLEAR, 32'h7F);
        wait_for(2, 1'b1, 60, "ctl back");
        $display("test nmi done");
        for (int i = 0; i < 5; i++) begin
            if (i != 1) begin
                wr(OFS_HOST_RESET_CAUSE, 32'h1F);
                pulse(i);
                wait_for(6, 1'b1, 4, "pin drive");
                wait_for(0, 1'b0, 4, "host reset");
                wait_for(9, 1'b0, 2, "epi reset");
                wait_for(6, 1'b0, 600, "pin release");
                wait_for(0, 1'b1, 60, "host back");
                rd(OFS_HOST_RESET_CAUSE, cause_of(i), 32'h1E, "cause");
            end
        end
        pulse(1);
        wait_for(7, 1'b1, 4, "analog pin drive");
        wait_for(4, 1'b0, 6, "analog reset");
        wait_for(7, 1'b0, 600, "analog pin release");
        wait_for(4, 1'b1, 60, "analog back");
        main_hold <= 1'b1;
        analog_hold <= 1'b1;
        wait_for(0, 1'b0, 6, "pin host");
        wait_for(1, 1'b0, 6, "pin ctl");
        wait_for(3, 1'b0, 6, "pin shared");
        wait_for(4, 1'b0, 6, "pin analog");
        main_hold <= 1'b0;
        analog_hold <= 1'b0;
        wait_for(1, 1'b1, 600, "ctl back");
        $display("test pins done");
        for (int pr = 0; pr < 2; pr++) begin
            for (int i = 5; i < 7; i++) begin
                wr(OFS_HOST_RESET_CAUSE, 32'h1F);
                wr(OFS_CTL_RESET_CONFIG, pr << CFG_PROPAGATE_BIT);
                pulse(i);
                wait_for(0, 1'b0, 4, "soft host");
                if (pr == 0) hold(1, 1'b1, 8, "no prop");
                if (pr == 1) wait_for(1, 1'b0, 6, "prop ctl");
                if (pr == 1) wait_for(3, 1'b0, 6, "prop shared");
                wait_for(0, 1'b1, 60, "host back");
                wait_for(2, 1'b1, 60, "ctl back");
                rd(OFS_HOST_RESET_CAUSE, (i == 5) ? 32'h10 : 32'h0, 32'h10, "soft cause");
            end
        end
        wr(OFS_CTL_RESET_CONFIG, 32'h1);
        wait_for(1, 1'b0, 6, "sel ctl");
        wait_for(2, 1'b0, 10, "ctl sys");
        rd(OFS_CTL_RESET_STATUS, 32'h1, 32'h1, "status on");
        wr(OFS_CTL_RESET_CONFIG, 32'h2);
        wait_for(2, 1'b1, 20, "ctl back");
        rd(OFS_CTL_RESET_STATUS, 32'h0, 32'h1, "status off");
        wait_for(5, 1'b0, 6, "bus reset");
        rd(OFS_DEVICE_CONFIG_STATUS, 32'h2, 32'h3, "devcfg status");
        wr(OFS_CTL_RESET_CONFIG, 32'h0);
        m = $urandom & 32'hFF;
        wr(OFS_DEVICE_CONFIG, m);
        wr(OFS_PERIPH_SOFT_RESET, 32'hFF);
        repeat (4) @(posedge pclk);
        chk({24'h0, periph_reset_n}, ~m & 32'hFF, "periph gated");
        wr(OFS_PERIPH_SOFT_RESET, 32'h0);
        repeat (4) @(posedge pclk);
        chk({24'h0, periph_reset_n}, 32'hFF, "periph release");
        $display("test config done");
        test_done();
    end
endmodule
